// ==== shared/frame_filter_pkg.sv ====
// Function
// - Sync code adds leading zero bytes
// - Drop frames shorter than four times minimum
// - Drop frames longer than four times maximum
// - Maximum field zero means 256 bytes
// - No minimum or maximum field length checks at 106k without sync detect
// - Wait-until-selected delays anticollision end
// - Wait-until-selected blocks active mode
// - Short slot halves 424k active slot
// - Upper three bits set decoder sensitivity
// - Two bits set decoder time constant
// - Halted card at 106k accepts only request 52h
// - Processor or state machine sets halted flag
// - RF reset clears halted flag
// - Response wait adds target delay with phase
package frame_filter_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    // Printed offsets are not all multiples of four, so they are indices.
    localparam logic [15:0] IDX_SYNC_MIN = 16'h630a;
    localparam logic [15:0] IDX_MAX_OPTS = 16'h630b;
    localparam logic [15:0] IDX_CARD_MODE = 16'h630c;
    localparam logic [15:0] IDX_RX_STATUS = 16'h630f;
    localparam logic [7:0] RST_SYNC_MIN = 8'h00;
    localparam logic [7:0] RST_MAX_OPTS = 8'h00;
    localparam logic [7:0] RST_CARD_MODE = 8'h62;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int SYNC_LEN_HI = 7;
    localparam int SYNC_LEN_LO = 6;
    localparam int LEN_HI = 5;
    localparam int LEN_LO = 0;
    localparam int WAIT_SEL_BIT = 7;
    localparam int HALF_SLOT_BIT = 6;
    localparam int SENS_HI = 7;
    localparam int SENS_LO = 5;
    localparam int TAU_HI = 4;
    localparam int TAU_LO = 3;
    localparam int HALT_BIT = 2;
    localparam int WAIT_HI = 1;
    localparam int WAIT_LO = 0;

    // -----------------------------------------------------------------
    // Frame constants
    // -----------------------------------------------------------------
    localparam logic [9:0] LEN_UNLIMITED = 10'h100;
    localparam logic [7:0] REQ_ALLOWED = 8'h52;
    localparam logic [7:0] SYNC_BYTE_A = 8'hb2;
    localparam logic [7:0] SYNC_BYTE_B = 8'h4d;
    localparam logic [7:0] SYNC_ZERO = 8'h00;

    // Returns the byte address of a register index.
    function automatic logic [31:0] reg_addr(input logic [15:0] idx);
        reg_addr = {14'h0000, idx, 2'b00};
    endfunction : reg_addr

endpackage : frame_filter_pkg

// ==== hdl/frame_fifo2.sv ====
`timescale 1ns/1ns
module frame_fifo2 (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] in_data,
    input wire logic in_last,
    input wire logic in_valid,
    output logic in_ready,
    output logic [8:0] out_word,
    output logic out_valid,
    input wire logic out_ready
);

    typedef struct packed {
        logic [1:0][8:0] mem;
        logic rd;
        logic wr;
        logic [1:0] cnt;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    // Two-entry buffer; full and empty follow the occupancy count.
    always_comb begin
        next_st = st;
        push = in_valid && (st.cnt != 2'd2);
        pop = out_ready && (st.cnt != 2'd0);
        if (push) begin
            next_st.mem[st.wr] = {in_last, in_data};
            next_st.wr = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = (st.cnt != 2'd2);
    assign out_valid = (st.cnt != 2'd0);
    assign out_word = st.mem[st.rd];

endmodule : frame_fifo2

// ==== hdl/sync_prefix_gen.sv ====
`timescale 1ns/1ns
module sync_prefix_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [1:0] sync_prefix_length,
    input wire logic out_ready,
    output logic [7:0] out_byte,
    output logic out_valid,
    output logic busy
);

    typedef struct packed {
        logic active;
        logic [2:0] left;
    } gen_state_t;

    gen_state_t st;
    gen_state_t next_st;

    // preamble length select
    // Emits length-code zero bytes, then the two sync pattern bytes.
    always_comb begin
        next_st = st;
        if (!st.active && start) begin
            next_st.active = 1'b1;
            next_st.left = {1'b0, sync_prefix_length} + 3'd2;
        end else if (st.active && out_ready) begin
            next_st.left = st.left - 3'd1;
            if (st.left == 3'd1) begin
                next_st.active = 1'b0;
            end
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid = st.active;
    assign busy = st.active;
    assign out_byte = (st.left == 3'd2) ? frame_filter_pkg::SYNC_BYTE_A :
                      (st.left == 3'd1) ? frame_filter_pkg::SYNC_BYTE_B : frame_filter_pkg::SYNC_ZERO;

endmodule : sync_prefix_gen

// ==== hdl/contactless_frame_filter_cfg.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module contactless_frame_filter_cfg (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive side from the decoder.
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    input wire logic rx_frame_end,
    input wire logic rate_106k,
    input wire logic rate_424k,
    input wire logic active_mode,
    input wire logic card_mode,
    input wire logic sync_detect_enable,
    // Card-mode and anticollision events.
    input wire logic rf_reset,
    input wire logic halt_entered,
    input wire logic select_done,
    input wire logic polling_done,
    input wire logic valid_cmd,
    input wire logic autocoll_busy,
    input wire logic request_seen,
    input wire logic [7:0] request_code,
    input wire logic [6:0] transmit_bit_phase,
    // Transmit preamble.
    input wire logic tx_start,
    input wire logic tx_ready,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    // Accepted frame data.
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_done,
    // Settings to the analog and mode logic.
    output logic [2:0] pause_decoder_sensitivity,
    output logic [1:0] pause_decoder_time_constant,
    output logic [8:0] response_delay,
    output logic half_slot_select,
    output logic active_allowed,
    output logic autocoll_end,
    output logic request_accept,
    output logic rx_stall
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_FILL = 3'b010,
        RX_DRAIN = 3'b100
    } rx_phase_t;

    typedef struct packed {
        logic [7:0] sync_min;
        logic [7:0] max_opts;
        logic [7:0] card_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        rx_phase_t phase;
        logic [9:0] count;
        logic [1:0] outcome;
        logic selected;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic [7:0] rx_data;
        logic rx_last;
        logic rx_valid;
        logic rx_done;
        logic [8:0] delay;
        logic autocoll_end;
        logic request_accept;
        logic rx_stall;
    } top_state_t;

    top_state_t st;
    top_state_t next_st;

    // Frame store: one frame up to the unlimited length.
    logic [7:0] store [0:255];
    logic [7:0] rd_ptr;
    logic [7:0] next_rd_ptr;

    logic [9:0] min_len;
    logic [9:0] max_len;
    logic checks_on;
    logic frame_ok;
    logic [7:0] fifo_in;
    logic fifo_in_last;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [8:0] fifo_word;
    logic fifo_valid;
    logic [7:0] gen_byte;
    logic gen_valid;
    logic bus_access;
    logic [15:0] word_idx;

    // Scales a six-bit length field by four bytes.
    function automatic logic [9:0] times_four(input logic [5:0] field);
        times_four = {2'b00, field, 2'b00};
    endfunction : times_four

    // -----------------------------------------------------------------
    // Length limits
    // -----------------------------------------------------------------
    // minimum length bound
    assign min_len = times_four(st.sync_min[frame_filter_pkg::LEN_HI:frame_filter_pkg::LEN_LO]);
    assign max_len = (st.max_opts[frame_filter_pkg::LEN_HI:frame_filter_pkg::LEN_LO] == 6'h00)
        ? frame_filter_pkg::LEN_UNLIMITED
        : times_four(st.max_opts[frame_filter_pkg::LEN_HI:frame_filter_pkg::LEN_LO]);
    assign checks_on = !(rate_106k && !sync_detect_enable);
    assign frame_ok = !checks_on || ((st.count >= min_len) && (st.count <= max_len));
    assign bus_access = psel && penable && !st.pready;
    assign word_idx = paddr[17:2];

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    // Registers, frame qualification, card-mode flags and outputs.
    always_comb begin
        next_st = st;
        next_rd_ptr = rd_ptr;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.rx_done = 1'b0;
        next_st.autocoll_end = 1'b0;
        next_st.request_accept = 1'b0;
        fifo_in = store[rd_ptr];
        fifo_in_last = 1'b0;
        fifo_in_valid = 1'b0;
        // APB access answered one cycle into the access phase.
        if (bus_access) begin
            next_st.pready = 1'b1;
            next_st.prdata = 32'h0000_0000;
            if (paddr[1:0] != 2'b00 || paddr[31:18] != 14'h0000) begin
                next_st.pslverr = 1'b1;
            end else begin
                unique case (word_idx)
                    frame_filter_pkg::IDX_SYNC_MIN: begin
                        next_st.prdata[7:0] = st.sync_min;
                        if (pwrite) next_st.sync_min = pwdata[7:0];
                    end
                    frame_filter_pkg::IDX_MAX_OPTS: begin
                        next_st.prdata[7:0] = st.max_opts;
                        if (pwrite) next_st.max_opts = pwdata[7:0];
                    end
                    frame_filter_pkg::IDX_CARD_MODE: begin
                        next_st.prdata[7:0] = st.card_mode;
                        if (pwrite) next_st.card_mode = pwdata[7:0];
                    end
                    frame_filter_pkg::IDX_RX_STATUS: begin
                        next_st.prdata[9:0] = st.count;
                        next_st.prdata[11:10] = st.outcome;
                        next_st.prdata[12] = st.selected;
                    end
                    default: begin
                        next_st.pslverr = 1'b1;
                    end
                endcase
            end
        end
        if (halt_entered) begin
            next_st.card_mode[frame_filter_pkg::HALT_BIT] = 1'b1;
        end
        if (rf_reset && !halt_entered) begin
            next_st.card_mode[frame_filter_pkg::HALT_BIT] = 1'b0;
        end
        if (request_seen) begin
            next_st.request_accept = !(card_mode && rate_106k && st.card_mode[frame_filter_pkg::HALT_BIT])
                || (request_code == frame_filter_pkg::REQ_ALLOWED);
        end
        if (!autocoll_busy) begin
            next_st.selected = 1'b0;
        end else if (select_done || polling_done) begin
            next_st.selected = 1'b1;
        end
        if (autocoll_busy && valid_cmd) begin
            next_st.autocoll_end = !st.max_opts[frame_filter_pkg::WAIT_SEL_BIT] || st.selected;
        end
        next_st.delay = {st.card_mode[frame_filter_pkg::WAIT_HI:frame_filter_pkg::WAIT_LO], transmit_bit_phase};
        // Frame capture, length check, then replay through the buffer.
        unique case (st.phase)
            RX_IDLE: begin
                next_st.rx_stall = 1'b0;
                if (rx_byte_valid) begin
                    next_st.phase = RX_FILL;
                    next_st.count = 10'h001;
                end
            end
            RX_FILL: begin
                if (rx_byte_valid && st.count < frame_filter_pkg::LEN_UNLIMITED + 10'h001) begin
                    next_st.count = st.count + 10'h001;
                end
                if (rx_frame_end) begin
                    if (frame_ok && st.count != 10'h000 && st.count <= frame_filter_pkg::LEN_UNLIMITED) begin
                        next_st.phase = RX_DRAIN;
                        next_st.outcome = 2'b01;
                        next_st.rx_stall = 1'b1;
                        next_rd_ptr = 8'h00;
                    end else begin
                        next_st.phase = RX_IDLE;
                        next_st.outcome = 2'b10;
                    end
                end
            end
            RX_DRAIN: begin
                fifo_in_valid = 1'b1;
                fifo_in_last = ({2'b00, rd_ptr} == st.count - 10'h001);
                if (fifo_in_ready) begin
                    next_rd_ptr = rd_ptr + 8'h01;
                    if (fifo_in_last) begin
                        next_st.phase = RX_IDLE;
                        next_st.rx_done = 1'b1;
                    end
                end
            end
            default: begin
                next_st.phase = RX_IDLE;
            end
        endcase
        // Output staging from the buffer and the preamble generator.
        if (!st.rx_valid || rx_ready) begin
            next_st.rx_valid = fifo_valid;
            next_st.rx_data = fifo_word[7:0];
            next_st.rx_last = fifo_word[8];
        end
        if (!st.tx_valid || tx_ready) begin
            next_st.tx_valid = gen_valid;
            next_st.tx_byte = gen_byte;
        end
    end

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // State register with reset values.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.sync_min <= frame_filter_pkg::RST_SYNC_MIN;
            st.max_opts <= frame_filter_pkg::RST_MAX_OPTS;
            st.card_mode <= frame_filter_pkg::RST_CARD_MODE;
            st.phase <= RX_IDLE;
            rd_ptr <= 8'h00;
        end else begin
            st <= next_st;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Frame store write, no reset needed for data.
    always_ff @(posedge pclk) begin
        if (rx_byte_valid && (st.phase == RX_IDLE || (st.phase == RX_FILL && st.count < 10'h100))) begin
            store[(st.phase == RX_IDLE) ? 8'h00 : st.count[7:0]] <= rx_byte;
        end
    end

    // -----------------------------------------------------------------
    // Submodules
    // -----------------------------------------------------------------
    frame_fifo2 u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(fifo_in),
        .in_last(fifo_in_last),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_word(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(!st.rx_valid || rx_ready)
    );

    sync_prefix_gen u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .start(tx_start),
        .sync_prefix_length(st.sync_min[frame_filter_pkg::SYNC_LEN_HI:frame_filter_pkg::SYNC_LEN_LO]),
        .out_ready(!st.tx_valid || tx_ready),
        .out_byte(gen_byte),
        .out_valid(gen_valid),
        .busy()
    );

    // Outputs straight from flip-flops, active_allowed through one inverter.
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign tx_byte = st.tx_byte;
    assign tx_valid = st.tx_valid;
    assign rx_data = st.rx_data;
    assign rx_last = st.rx_last;
    assign rx_valid = st.rx_valid;
    assign rx_done = st.rx_done;
    assign pause_decoder_sensitivity = st.card_mode[frame_filter_pkg::SENS_HI:frame_filter_pkg::SENS_LO];
    assign pause_decoder_time_constant = st.card_mode[frame_filter_pkg::TAU_HI:frame_filter_pkg::TAU_LO];
    assign response_delay = st.delay;
    assign half_slot_select = st.max_opts[frame_filter_pkg::HALF_SLOT_BIT];
    assign active_allowed = !st.max_opts[frame_filter_pkg::WAIT_SEL_BIT];
    assign autocoll_end = st.autocoll_end;
    assign request_accept = st.request_accept;
    assign rx_stall = st.rx_stall;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_one_wait_a: assert property (psel && penable && !pready |=> pready) else $error("apb no answer");
    rf_clear_a: assert property (rf_reset && !halt_entered && !bus_access |=> !st.card_mode[2]) else $error("halt kept");
    halt_set_a: assert property (halt_entered |=> st.card_mode[2]) else $error("halt not set");
    halt_filter_a: assert property (request_seen && card_mode && rate_106k && st.card_mode[2]
        && request_code != frame_filter_pkg::REQ_ALLOWED |=> !request_accept) else $error("request passed");
    short_drop_a: assert property (st.phase == RX_FILL && rx_frame_end && checks_on && st.count < min_len
        |=> st.phase == RX_IDLE && !rx_done) else $error("short frame kept");
    long_drop_a: assert property (st.phase == RX_FILL && rx_frame_end && checks_on && st.count > max_len
        |=> st.phase == RX_IDLE) else $error("long frame kept");
    zero_max_a: assert property (st.max_opts[5:0] == 6'h00 |-> max_len == 10'h100) else $error("max zero");
    wait_sel_a: assert property (autocoll_busy && valid_cmd && st.max_opts[7] && !st.selected
        |=> !autocoll_end) else $error("early end");
    active_block_a: assert property (st.max_opts[7] |-> !active_allowed) else $error("active on");
    cover_accept_c: cover property (rx_done);
    cover_reject_c: cover property (st.phase == RX_FILL && rx_frame_end && !frame_ok);
    cover_halt_c: cover property (halt_entered ##[1:20] rf_reset);
    cover_end_c: cover property (autocoll_end);

endmodule : contactless_frame_filter_cfg

// ==== testbench/rf_peer.sv ====
`timescale 1ns/1ns
// ---------------------------------
// Remote peer feeding received bytes
// ---------------------------------
module rf_peer (
    input wire logic pclk,
    output logic [7:0] rx_byte,
    output logic rx_byte_valid,
    output logic rx_frame_end
);
    // Idle state at time zero.
    initial begin
        rx_byte = 8'h00;
        rx_byte_valid = 1'b0;
        rx_frame_end = 1'b0;
    end

    // Sends n bytes then the end marker; data flips when not valid.
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rx_byte <= 8'(i * 37 + 5);
            rx_byte_valid <= 1'b1;
            @(posedge pclk);
            rx_byte_valid <= 1'b0;
            rx_byte <= ~rx_byte;
        end
        @(posedge pclk);
        rx_frame_end <= 1'b1;
        @(posedge pclk);
        rx_frame_end <= 1'b0;
    endtask : send
endmodule : rf_peer

// ==== testbench/tb_contactless_frame_filter_cfg.sv ====
`timescale 1ns/1ns
module tb_contactless_frame_filter_cfg;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [31:0] paddr = '0, pwdata = '0, prdata, q, v;
    logic rate_106k = 1'b0, rate_424k = 1'b0, active_mode = 1'b0, card_mode = 1'b0;
    logic sync_detect_enable = 1'b1, autocoll_busy = 1'b0, tx_ready = 1'b1, rx_ready = 1'b1;
    logic [6:0] ev = '0, transmit_bit_phase = '0;
    logic [7:0] request_code = '0, rx_byte, tx_byte, rx_data, tx_last = '0;
    logic rx_byte_valid, rx_frame_end, tx_valid, rx_last, rx_valid, rx_done, half_slot_select;
    logic active_allowed, autocoll_end, request_accept, rx_stall;
    logic [2:0] pause_decoder_sensitivity;
    logic [1:0] pause_decoder_time_constant;
    logic [8:0] response_delay;
    int err_total = 0, total_checks = 0, cyc = 0, words = 0, dones = 0, txn = 0, ends = 0, accs = 0, k, flen = 0;

    contactless_frame_filter_cfg uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_byte, .rx_byte_valid, .rx_frame_end, .rate_106k, .rate_424k, .active_mode,
        .card_mode, .sync_detect_enable, .rf_reset(ev[4]), .halt_entered(ev[3]), .select_done(ev[2]),
        .polling_done(ev[1]), .valid_cmd(ev[0]), .autocoll_busy, .request_seen(ev[6]), .request_code,
        .transmit_bit_phase, .tx_start(ev[5]), .tx_ready, .tx_byte, .tx_valid, .rx_data, .rx_last, .rx_valid,
        .rx_ready, .rx_done, .pause_decoder_sensitivity, .pause_decoder_time_constant, .response_delay,
        .half_slot_select, .active_allowed, .autocoll_end, .request_accept, .rx_stall);
    rf_peer peer (.pclk, .rx_byte, .rx_byte_valid, .rx_frame_end);

    // Clock of 8 ns.
    always #4 pclk = ~pclk;

    // Random stalls, event counters and the hang limit.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        rx_ready <= ($urandom % 4) != 0;
        tx_ready <= ($urandom % 3) != 0;
        if (rx_valid && rx_ready) begin
            words <= words + 1;
            chk("rx word", {rx_last, rx_data}, {words == flen - 1, exp_byte(words)});
        end
        if (rx_done) dones <= dones + 1;
        if (autocoll_end) ends <= ends + 1;
        if (request_accept) accs <= accs + 1;
        if (tx_valid && tx_ready) begin
            txn <= txn + 1;
            tx_last <= tx_byte;
        end
        if (cyc == 60000) begin
            err_total++;
            close_out();
        end
    end

    function automatic logic [31:0] ad(input logic [15:0] i);
        return {14'h0000, i, 2'b00};
    endfunction : ad

    // Byte that the peer puts at position i of a frame.
    function automatic logic [7:0] exp_byte(input int i);
        return 8'(i * 37 + 5);
    endfunction : exp_byte

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    // One APB transfer held until pready is sampled high.
    task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad(i);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [15:0] i, input logic [7:0] x);
        apb(1'b0, i, '0);
        chk("register", q, {24'h000000, x});
    endtask : rd

    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev[b] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    // Sends one frame and counts what comes out on the receive side.
    task automatic frame(input int n, input logic ok);
        flen = n;
        words = 0;
        dones = 0;
        peer.send(n);
        for (k = 0; k < 4000 && words < (ok ? n : 0); k++) @(posedge pclk);
        repeat (30) @(posedge pclk);
        chk("words", words, ok ? n : 0);
        chk("done", dones, {31'h0, ok});
        chk("stall", rx_stall, 32'h0);
        apb(1'b0, 16'h630f, '0);
        chk("status", q, {20'h00000, ok ? 2'b01 : 2'b10, 10'(n)});
    endtask : frame

    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Main sequence.
    initial begin
        void'($urandom(32'h2182d47b));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(16'h630a, 8'h00);
        rd(16'h630b, 8'h00);
        rd(16'h630c, 8'h62);
        apb(1'b0, 16'h6300, '0);
        chk("slverr", e, 1);
        repeat (8) begin
            v = $urandom;
            transmit_bit_phase <= 7'($urandom);
            apb(1'b1, 16'h630b, v);
            rd(16'h630b, v[7:0]);
            chk("half", half_slot_select, v[6]);
            chk("active", active_allowed, !v[7]);
            v[2] = 1'b0;
            apb(1'b1, 16'h630c, v);
            rd(16'h630c, v[7:0]);
            chk("sens", pause_decoder_sensitivity, v[7:5]);
            chk("tau", pause_decoder_time_constant, v[4:3]);
            chk("delay", response_delay, {v[1:0], transmit_bit_phase});
        end
        card_mode <= 1'b1;
        rate_106k <= 1'b1;
        apb(1'b1, 16'h630c, 32'h00000066);
        accs = 0;
        request_code <= 8'h52;
        pulse(6);
        request_code <= 8'h26;
        pulse(6);
        chk("accept", accs, 1);
        pulse(4);
        rd(16'h630c, 8'h62);
        pulse(3);
        rd(16'h630c, 8'h66);
        pulse(4);
        rd(16'h630c, 8'h62);
        apb(1'b1, 16'h630b, 32'h00000080);
        for (int p = 1; p <= 2; p++) begin
            autocoll_busy <= 1'b1;
            pulse(0);
            chk("early end", ends, p - 1);
            pulse(p);
            pulse(0);
            chk("end", ends, p);
            autocoll_busy <= 1'b0;
            @(posedge pclk);
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 16'h630a, {24'h000000, 2'(c), 6'h00});
            txn = 0;
            pulse(5);
            for (k = 0; k < 400 && txn < c + 2; k++) @(posedge pclk);
            repeat (10) @(posedge pclk);
            chk("preamble", txn, c + 2);
            chk("sync tail", tx_last, 8'h4d);
        end
        card_mode <= 1'b0;
        rate_106k <= 1'b0;
        apb(1'b1, 16'h630a, 32'h00000002);
        apb(1'b1, 16'h630b, 32'h00000003);
        frame(7, 1'b0);
        frame(8, 1'b1);
        frame(12, 1'b1);
        frame(13, 1'b0);
        apb(1'b1, 16'h630b, 32'h00000000);
        frame(256, 1'b1);
        rate_106k <= 1'b1;
        sync_detect_enable <= 1'b0;
        frame(3, 1'b1);
        close_out();
    end
endmodule : tb_contactless_frame_filter_cfg
